// ---- hw/pcc_cfg.svh ----
// Field positions, page index codes and channel constants of the parameter channel codec
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH

// ------------------------------------------------------------
// Word 1 layout
// ------------------------------------------------------------
`define PCC_ID_MSB          15
`define PCC_ID_LSB          12
`define PCC_PNUM_MSB        10
`define PCC_PNUM_LSB        0
// ------------------------------------------------------------
// Word 2 layout
// ------------------------------------------------------------
`define PCC_SUB_MSB         15
`define PCC_SUB_LSB         8
`define PCC_PAGE_MSB        7
`define PCC_PAGE_LSB        0
// ------------------------------------------------------------
// Page index codes and their offsets
// ------------------------------------------------------------
`define PCC_PAGE_0          8'h00
`define PCC_PAGE_2000       8'h80
`define PCC_PAGE_6000       8'h90
`define PCC_PAGE_8000       8'h20
`define PCC_PAGE_10000      8'hA0
`define PCC_PAGE_20000      8'h50
`define PCC_PAGE_30000      8'hF0
`define PCC_PAGE_60000      8'h74
`define PCC_OFS_0           16'h0000
`define PCC_OFS_2000        16'h07D0
`define PCC_OFS_6000        16'h1770
`define PCC_OFS_8000        16'h1F40
`define PCC_OFS_10000       16'h2710
`define PCC_OFS_20000       16'h4E20
`define PCC_OFS_30000       16'h7530
`define PCC_OFS_60000       16'hEA60
`define PCC_RANGE_SPAN      16'h07D0
// ------------------------------------------------------------
// Connector and error codes
// ------------------------------------------------------------
`define PCC_CONN_MSB        15
`define PCC_CONN_LSB        10
`define PCC_CONN_CODE       6'h3F
`define PCC_ERR_NO_PARAM    16'h0000
`define PCC_ERR_NOT_SUPP    16'h006A
`define PCC_ERR_NO_CONTROL  16'h000B

`endif

// ---- hw/pcc_pkg.sv ----
// Types of the parameter channel codec
package pcc_pkg;

   // ------------------------------------------------------------
   // Channel: four 16-bit words in wire order
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] idNumberWord;
      logic [15:0] indexWord;
      logic [15:0] valueHighWord;
      logic [15:0] valueLowWord;
   } pcc_channel_type;

   typedef enum logic [3:0] {
      PCC_REQ_NONE      = 4'h0,
      PCC_REQ_READ_OLD  = 4'h1,
      PCC_REQ_WRITE_OLD = 4'h2,
      PCC_REQ_DWORD_OLD = 4'h3,
      PCC_REQ_READ_FLD  = 4'h6,
      PCC_REQ_WRITE_FLD = 4'h7,
      PCC_REQ_WRITE_DW  = 4'h8
   } pcc_request_type;

   typedef enum logic [3:0] {
      PCC_RSP_NONE      = 4'h0,
      PCC_RSP_WORD      = 4'h1,
      PCC_RSP_DWORD     = 4'h2,
      PCC_RSP_FLD_WORD  = 4'h4,
      PCC_RSP_FLD_DWORD = 4'h5,
      PCC_RSP_COUNT     = 4'h6,
      PCC_RSP_ERROR     = 4'h7,
      PCC_RSP_NO_AUTH   = 4'h8
   } pcc_response_type;

   // Decoded request handed to the parameter store
   typedef struct packed {
      logic [15:0] paramNumber;
      logic [7:0]  subindex;
      logic [31:0] value;
      logic        isConnector;
      logic [15:0] connNumber;
      logic [9:0]  connIndex;
   } pcc_access_type;

   // Answer coming back from the parameter store
   typedef struct packed {
      logic        ok;
      logic        isDword;
      logic        isCount;
      logic [15:0] errorNumber;
      logic [31:0] value;
   } pcc_result_type;

endpackage : pcc_pkg

// ---- hw/pcc_page_decode.sv ----
// Page index to parameter number offset decoder
`timescale 1ns/100ps
`include "pcc_cfg.svh"

module pcc_page_decode (
   // Received fields
   input  wire logic [7:0]  pageIndex,
   input  wire logic [10:0] paramField,
   // Rebuilt number
   output logic      [15:0] paramNumber,
   output logic             pageValid
);

   logic [15:0] offset;
   logic        known;

   assign known = (pageIndex == `PCC_PAGE_0)     || (pageIndex == `PCC_PAGE_2000)
               || (pageIndex == `PCC_PAGE_6000)  || (pageIndex == `PCC_PAGE_8000)
               || (pageIndex == `PCC_PAGE_10000) || (pageIndex == `PCC_PAGE_20000)
               || (pageIndex == `PCC_PAGE_30000) || (pageIndex == `PCC_PAGE_60000);

   assign offset = (pageIndex == `PCC_PAGE_2000)  ? `PCC_OFS_2000  :
                   (pageIndex == `PCC_PAGE_6000)  ? `PCC_OFS_6000  :
                   (pageIndex == `PCC_PAGE_8000)  ? `PCC_OFS_8000  :
                   (pageIndex == `PCC_PAGE_10000) ? `PCC_OFS_10000 :
                   (pageIndex == `PCC_PAGE_20000) ? `PCC_OFS_20000 :
                   (pageIndex == `PCC_PAGE_30000) ? `PCC_OFS_30000 :
                   (pageIndex == `PCC_PAGE_60000) ? `PCC_OFS_60000 :
                   `PCC_OFS_0;

   // Field at or above the span is refused; the offset must come from the page index
   assign pageValid   = known && ({5'h00, paramField} < `PCC_RANGE_SPAN);
   assign paramNumber = 16'(offset + {5'h00, paramField});

endmodule : pcc_page_decode

// ---- hw/pcc_codec.sv ----
// Device end of the parameter channel: decodes requests, builds responses
`timescale 1ns/100ps
`include "pcc_cfg.svh"

// What this block does
// - Page codes 00,80,90,20,A0,50,F0,74 mean 0..60000 offsets.
// - Device adds the page offset to the number field.
// - Values: 8-bit low byte, 16-bit low word, 32-bit both words.
// - Connector: word three number, 3F in bits 15..10, index below.
// - Identifier in word one bits 15..12; 6 reads a field value.
// - Identifier 7 writes a field word value from the low value word.
// - Four 16-bit words; high value word carries bits 31..16.
// - Response codes 1,2,4,5,6,8 as the access outcome dictates.
// - Failure answers 7 with an error number in the top word.
// - Identifiers 1,2,3 act as 6,7,8.
module pcc_codec (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   // Request from the fieldbus
   input  wire logic                    reqValid,
   input  wire pcc_pkg::pcc_channel_type reqChannel,
   input  wire logic                    hasControl,
   // Parameter store side
   output pcc_pkg::pcc_access_type      access,
   output logic                         accessRead,
   output logic                         accessWrite,
   input  wire logic                    resultValid,
   input  wire pcc_pkg::pcc_result_type result,
   // Response to the fieldbus
   output logic                         rspValid,
   output pcc_pkg::pcc_channel_type     rspChannel,
   output logic                         busy
);

   typedef enum logic [1:0] {IDLE, WAIT, ANSWER} pcc_state_type;

   pcc_state_type            state;
   pcc_state_type            next_state;
   pcc_pkg::pcc_channel_type next_rsp;
   logic                     isField;
   logic                     next_rspValid;
   logic                     next_busy;
   logic                     next_isField;
   logic                     next_accessRead;
   logic                     next_accessWrite;

   logic [3:0]  reqId;
   logic [3:0]  normId;
   logic [15:0] paramNumber;
   logic        pageValid;
   logic        isRead;
   logic        isWrite;
   logic        isDwWrite;
   logic        supported;
   logic        connValue;
   logic        start;
   logic        earlyFail;
   logic [3:0]  earlyCode;
   logic [15:0] earlyErr;
   logic [3:0]  okCode;
   logic [31:0] writeValue;

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   pcc_page_decode pageDecode (
      .pageIndex   (reqChannel.indexWord[`PCC_PAGE_MSB:`PCC_PAGE_LSB]),
      .paramField  (reqChannel.idNumberWord[`PCC_PNUM_MSB:`PCC_PNUM_LSB]),
      .paramNumber (paramNumber),
      .pageValid   (pageValid)
   );

   assign reqId     = reqChannel.idNumberWord[`PCC_ID_MSB:`PCC_ID_LSB];
   assign normId    = (reqId == pcc_pkg::PCC_REQ_READ_OLD  ||
                       reqId == pcc_pkg::PCC_REQ_WRITE_OLD ||
                       reqId == pcc_pkg::PCC_REQ_DWORD_OLD) ? reqId + 4'h5 : reqId;
   assign isRead    = (normId == pcc_pkg::PCC_REQ_READ_FLD);
   assign isWrite   = (normId == pcc_pkg::PCC_REQ_WRITE_FLD);
   assign isDwWrite = (normId == pcc_pkg::PCC_REQ_WRITE_DW);
   assign supported = isRead || isWrite || isDwWrite;
   assign connValue = (reqChannel.valueLowWord[`PCC_CONN_MSB:`PCC_CONN_LSB]
                       == `PCC_CONN_CODE);

   // Word writes take only the low word, so a stale high word cannot leak in
   assign writeValue = isWrite ? {16'h0000, reqChannel.valueLowWord}
                               : {reqChannel.valueHighWord, reqChannel.valueLowWord};

   assign start     = reqValid && (state == IDLE) && (normId != pcc_pkg::PCC_REQ_NONE);
   assign earlyFail = !supported || !pageValid || (!isRead && !hasControl);
   assign earlyCode = (supported && !isRead && !hasControl) ? pcc_pkg::PCC_RSP_NO_AUTH
                                                             : pcc_pkg::PCC_RSP_ERROR;
   assign earlyErr  = !supported ? `PCC_ERR_NOT_SUPP : `PCC_ERR_NO_PARAM;

   assign okCode = result.isCount ? pcc_pkg::PCC_RSP_COUNT :
                   isField        ? (result.isDword ? pcc_pkg::PCC_RSP_FLD_DWORD
                                                    : pcc_pkg::PCC_RSP_FLD_WORD)
                                  : (result.isDword ? pcc_pkg::PCC_RSP_DWORD
                                                    : pcc_pkg::PCC_RSP_WORD);

   // ------------------------------------------------------------
   // Response build
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_rsp   = rspChannel;
      unique case (state)
         IDLE: begin
            if (start) begin
               next_rsp.idNumberWord = reqChannel.idNumberWord;
               next_rsp.indexWord    = reqChannel.indexWord;
               if (earlyFail) begin
                  next_rsp.idNumberWord[`PCC_ID_MSB:`PCC_ID_LSB] = earlyCode;
                  next_rsp.valueHighWord = earlyErr;
                  next_rsp.valueLowWord  = 16'h0000;
                  next_state = ANSWER;
               end else begin
                  next_state = WAIT;
               end
            end
         end
         WAIT: begin
            if (resultValid) begin
               if (result.ok) begin
                  next_rsp.idNumberWord[`PCC_ID_MSB:`PCC_ID_LSB] = okCode;
                  next_rsp.valueHighWord = result.value[31:16];
                  next_rsp.valueLowWord  = result.value[15:0];
               end else begin
                  next_rsp.idNumberWord[`PCC_ID_MSB:`PCC_ID_LSB] = pcc_pkg::PCC_RSP_ERROR;
                  next_rsp.valueHighWord = result.errorNumber;
                  next_rsp.valueLowWord  = 16'h0000;
               end
               next_state = ANSWER;
            end
         end
         ANSWER: begin
            next_state = IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Strobe and busy both follow the next state, so they always end together
   assign next_rspValid = (next_state == ANSWER);
   assign next_busy     = (next_state != IDLE);
   // Answer code needs the request kind long after the request is gone
   assign next_isField  = start ? (isRead || isWrite) : isField;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rspChannel <= '0;
      end else begin
         rspChannel <= next_rsp;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rspValid <= 1'b0;
         busy     <= 1'b0;
      end else begin
         rspValid <= next_rspValid;
         busy     <= next_busy;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         isField <= 1'b0;
      end else begin
         isField <= next_isField;
      end
   end

   // ------------------------------------------------------------
   // Store request
   // ------------------------------------------------------------
   assign next_accessRead  = start && !earlyFail && isRead;
   assign next_accessWrite = start && !earlyFail && !isRead;

   // One-cycle strobes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         accessRead  <= 1'b0;
         accessWrite <= 1'b0;
      end else begin
         accessRead  <= next_accessRead;
         accessWrite <= next_accessWrite;
      end
   end

   // Fields held until the next request, so a slow store may read them late
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         access <= '0;
      end else if (start) begin
         access.paramNumber <= paramNumber;
         access.subindex    <= reqChannel.indexWord[`PCC_SUB_MSB:`PCC_SUB_LSB];
         // Read requests zero the value; connNumber and connIndex still copy the value words
         access.value       <= isRead ? 32'h0000_0000 : writeValue;
         access.isConnector <= !isRead && connValue;
         access.connNumber  <= reqChannel.valueHighWord;
         access.connIndex   <= reqChannel.valueLowWord[9:0];
      end
   end

endmodule : pcc_codec

// ---- bench/pcc_codec_properties.sv ----
// Checker of the parameter channel codec ports
`timescale 1ns/100ps
module pcc_codec_checker (
   // Clock and reset
   input wire logic                     core_clk,
   input wire logic                     rst_n,
   // Request side
   input wire logic                     reqValid,
   input wire pcc_pkg::pcc_channel_type reqChannel,
   input wire logic                     hasControl,
   // Store side
   input wire pcc_pkg::pcc_access_type  access,
   input wire logic                     accessRead,
   input wire logic                     accessWrite,
   input wire logic                     resultValid,
   input wire pcc_pkg::pcc_result_type  result,
   // Response side
   input wire logic                     rspValid,
   input wire pcc_pkg::pcc_channel_type rspChannel,
   input wire logic                     busy
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire logic [3:0] reqId = reqChannel.idNumberWord[15:12];
   wire logic [3:0] rspId = rspChannel.idNumberWord[15:12];
   wire logic [7:0] page  = reqChannel.indexWord[7:0];
   wire logic       take  = !busy && reqValid;
   wire logic       fldOk = reqChannel.idNumberWord[10:0] < 11'd2000;
   wire logic       plain = take && page == 8'h00 && fldOk;
   wire logic       pgOk  = page inside {8'h00, 8'h80, 8'h90, 8'h20, 8'hA0, 8'h50, 8'hF0, 8'h74};

   property p_bad_page;
      take && reqId == 4'h6 && !pgOk |=> rspValid && rspId == 4'h7 && rspChannel.valueHighWord == 16'h0000;
   endproperty
   a_bad_page: assert property (p_bad_page) else $error("bad page not refused");
   property p_page_ofs;
      take && reqId == 4'h6 && page == 8'h74 && fldOk
         |=> accessRead && access.paramNumber == 16'hEA60 + {5'h00, $past(reqChannel.idNumberWord[10:0])};
   endproperty
   a_page_ofs: assert property (p_page_ofs) else $error("offset not added");
   property p_old_id;
      take && reqId == 4'h1 && pgOk && fldOk |=> accessRead && !accessWrite;
   endproperty
   a_old_id: assert property (p_old_id) else $error("old read id not mapped");
   property p_unsupp;
      take && reqId == 4'h4 |=> rspValid && rspId == 4'h7 && rspChannel.valueHighWord == 16'h006A;
   endproperty
   a_unsupp: assert property (p_unsupp) else $error("unsupported id not refused");
   property p_no_auth;
      plain && reqId == 4'h7 && !hasControl |=> rspValid && rspId == 4'h8 && !accessWrite;
   endproperty
   a_no_auth: assert property (p_no_auth) else $error("write without authority");
   property p_word_write;
      plain && reqId == 4'h7 && hasControl && reqChannel.valueLowWord[15:10] != 6'h3F
         |=> accessWrite && access.value == {16'h0000, $past(reqChannel.valueLowWord)};
   endproperty
   a_word_write: assert property (p_word_write) else $error("word write value wrong");
   property p_conn;
      plain && reqId == 4'h8 && hasControl && reqChannel.valueLowWord[15:10] == 6'h3F
         |=> access.isConnector && access.connNumber == $past(reqChannel.valueHighWord)
             && access.connIndex == $past(reqChannel.valueLowWord[9:0]);
   endproperty
   a_conn: assert property (p_conn) else $error("connector not decoded");
   property p_store_err;
      busy && !rspValid && resultValid && !result.ok
         |=> rspValid && rspId == 4'h7 && rspChannel.valueHighWord == $past(result.errorNumber);
   endproperty
   a_store_err: assert property (p_store_err) else $error("error answer wrong");
   property p_busy_end;
      rspValid |-> busy ##1 !busy && !rspValid;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy not ending with answer");
endmodule : pcc_codec_checker

bind pcc_codec pcc_codec_checker u_pcc_codec_checker (.core_clk(core_clk), .rst_n(rst_n),
   .reqValid(reqValid), .reqChannel(reqChannel), .hasControl(hasControl), .access(access),
   .accessRead(accessRead), .accessWrite(accessWrite), .resultValid(resultValid),
   .result(result), .rspValid(rspValid), .rspChannel(rspChannel), .busy(busy));

// ---- bench/pcc_store_model.sv ----
// Parameter store model answering the codec, promptly or slowly
`timescale 1ns/100ps
module pcc_store_model (
   // Clock and reset
   input wire logic                    core_clk,
   input wire logic                    rst_n,
   // Access from the codec
   input wire pcc_pkg::pcc_access_type access,
   input wire logic                    accessRead,
   input wire logic                    accessWrite,
   input wire logic                    slow,
   // Answer
   output logic                        resultValid,
   output pcc_pkg::pcc_result_type     result
);
   logic       pend;
   logic [2:0] waitCnt;
   // Number 1999 is refused so that the error path is reachable
   assign result = {access.paramNumber != 16'd1999, 2'b00, 16'h0014, access.paramNumber, 8'h00,
                    access.subindex};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend <= 1'b0;
         waitCnt <= 3'h0;
         resultValid <= 1'b0;
      end else begin
         resultValid <= 1'b0;
         if (accessRead || accessWrite) begin
            pend <= 1'b1;
            waitCnt <= slow ? 3'h4 : 3'h0;
         end else if (pend && waitCnt != 3'h0) begin
            waitCnt <= waitCnt - 3'h1;
         end else if (pend) begin
            pend <= 1'b0;
            resultValid <= 1'b1;
         end
      end
   end
endmodule : pcc_store_model

// ---- bench/tb.sv ----
// Self-checking testbench of the parameter channel codec
`timescale 1ns/100ps
module tb;
   logic                     core_clk = 1'b0;
   logic                     rst_n = 1'b0;
   logic                     reqValid = 1'b0;
   logic                     hasControl = 1'b0;
   logic                     slow = 1'b0;
   pcc_pkg::pcc_channel_type reqChannel = '0;
   pcc_pkg::pcc_channel_type rspChannel;
   pcc_pkg::pcc_channel_type rsp;
   pcc_pkg::pcc_access_type  access;
   pcc_pkg::pcc_result_type  result;
   logic                     accessRead, accessWrite, resultValid, rspValid, busy;
   int                       miscompares = 0;
   int                       samples_checked = 0;
   int                       ofs [8] = '{0, 2000, 6000, 8000, 10000, 20000, 30000, 60000};
   logic [7:0]               code [8] = '{8'h00, 8'h80, 8'h90, 8'h20, 8'hA0, 8'h50, 8'hF0, 8'h74};

   always #5 core_clk = ~core_clk;

   pcc_codec u_pcc_codec (.core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid),
      .reqChannel(reqChannel), .hasControl(hasControl), .access(access), .accessRead(accessRead),
      .accessWrite(accessWrite), .resultValid(resultValid), .result(result),
      .rspValid(rspValid), .rspChannel(rspChannel), .busy(busy));
   pcc_store_model u_pcc_store_model (.core_clk(core_clk), .rst_n(rst_n), .access(access),
      .accessRead(accessRead), .accessWrite(accessWrite), .slow(slow),
      .resultValid(resultValid), .result(result));

   task automatic wrap_up;
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rchk(input logic [3:0] id, input logic [15:0] hi);
      chk({28'h0, rsp.idNumberWord[15:12]}, {28'h0, id});
      chk({16'h0, rsp.valueHighWord}, {16'h0, hi});
   endtask : rchk

   // One request, held for the taking edge, then wait for the answer
   task automatic req(input logic [3:0] id, input logic [10:0] pnum, input logic [7:0] sub,
                      input logic [7:0] page, input logic [15:0] hi, input logic [15:0] lo,
                      input logic ctl);
      int n;
      reqChannel = {id, 1'b0, pnum, sub, page, hi, lo};
      hasControl = ctl;
      reqValid = 1'b1;
      @(posedge core_clk);
      #1;
      reqValid = 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 50) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n == 50) begin
         miscompares++;
         $display("MISMATCH at %0t: no answer", $time);
         wrap_up();
      end
      rsp = rspChannel;
      // Codec is idle only one edge after its answer; an earlier request is lost
      @(posedge core_clk);
      #1;
   endtask : req

   initial begin
      repeat (8) @(posedge core_clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         req(4'h6, 11'd100, 8'h02, code[i], 16'h0000, 16'h0000, 1'b0);
         chk({16'h0, access.paramNumber}, ofs[i] + 100);
         rchk(4'h4, 16'(ofs[i] + 100));
         chk({16'h0, rsp.indexWord}, {16'h0, 8'h02, code[i]});
         chk({16'h0, rsp.valueLowWord}, 32'h0000_0002);
      end
      req(4'h1, 11'd1841, 8'h02, 8'h90, 16'h0000, 16'h0000, 1'b0);
      rchk(4'h4, 16'd7841);
      req(4'h6, 11'd100, 8'h00, 8'h81, 16'h0000, 16'h0000, 1'b0);
      rchk(4'h7, 16'h0000);
      req(4'h6, 11'd2000, 8'h00, 8'h00, 16'h0000, 16'h0000, 1'b0);
      rchk(4'h7, 16'h0000);
      req(4'h4, 11'd100, 8'h00, 8'h00, 16'h0000, 16'h0000, 1'b1);
      rchk(4'h7, 16'h006A);
      req(4'h7, 11'h4BA, 8'h00, 8'h00, 16'h0000, 16'h001A, 1'b0);
      chk({28'h0, rsp.idNumberWord[15:12]}, 32'h8);
      req(4'h7, 11'h4BA, 8'h00, 8'h00, 16'hBEEF, 16'h001A, 1'b1);
      chk(access.value, 32'h0000_001A);
      rchk(4'h4, 16'd1210);
      req(4'h8, 11'd5, 8'h00, 8'h00, 16'h1234, 16'h5678, 1'b1);
      chk(access.value, 32'h1234_5678);
      rchk(4'h1, 16'd5);
      req(4'h8, 11'h348, 8'h01, 8'h00, 16'h02D2, {6'h3F, 10'h002}, 1'b1);
      chk({5'h0, access.isConnector, access.connNumber, access.connIndex},
          {5'h0, 1'b1, 16'h02D2, 10'h002});
      slow = 1'b1;
      req(4'h6, 11'd1999, 8'h00, 8'h00, 16'hFFFF, 16'hFFFF, 1'b0);
      chk(access.value, 32'h0000_0000);
      rchk(4'h7, 16'h0014);
      wrap_up();
   end
endmodule : tb
